// ===== rtl/fspc_core.sv
// Purpose: control of a five-stage integer pipeline with two phases per stage
// Assumes: caches and translation buffers answer with ready/miss levels
// Notes:   phase_reg alternates each clk; a stage advances at the end of phase 2
`timescale 1ns/1ps
module fspc_core #(
	parameter int XLEN = fspc_pkg::FSPC_XLEN
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// instruction side
	output logic [XLEN-1:0]       fetch_addr,
	output logic                  itrans_start,
	output logic                  icache_start,
	output logic [XLEN-1:0]       alt_fetch_addr,
	input  wire logic [31:0]      fetch_insn,
	input  wire logic             instr_translation_miss,
	input  wire logic             instr_cache_miss,
	// data side
	output logic                  dcache_start,
	output logic                  dtrans_start,
	output logic                  jtrans_start,
	output logic [XLEN-1:0]       data_addr,
	output logic [XLEN-1:0]       store_data,
	output logic                  store_en,
	input  wire logic [XLEN-1:0]  load_raw,
	input  wire logic             data_cache_miss,
	input  wire logic             coproc_possible_exception,
	// resource slips
	input  wire logic             muldiv_start_slip,
	input  wire logic             fp_coproc_busy_slip,
	// register file
	output logic [4:0]            rf_raddr_a,
	output logic [4:0]            rf_raddr_b,
	input  wire logic [XLEN-1:0]  rf_rdata_a,
	input  wire logic [XLEN-1:0]  rf_rdata_b,
	output logic                  rf_we,
	output logic [4:0]            rf_waddr,
	output logic [XLEN-1:0]       rf_wdata,
	// status
	output logic                  stall,
	output logic                  slip,
	output logic                  reserved_instr_exception,
	output logic [XLEN-1:0]       exc_pc
);
	import fspc_pkg::*;

	// ****************************************
	// pipeline state
	// ****************************************
	fspc_phase_t      phase_reg, phase_next;
	logic [XLEN-1:0]  pc_reg, pc_next;
	logic [XLEN-1:0]  redir_reg, redir_next;
	logic             redir_v_reg, redir_v_next;
	logic             r_v_reg, r_v_next;
	logic [31:0]      r_insn_reg, r_insn_next;
	logic [XLEN-1:0]  r_pc_reg, r_pc_next;
	logic             a_v_reg, a_v_next;
	logic [31:0]      a_insn_reg, a_insn_next;
	logic [XLEN-1:0]  a_pc_reg, a_pc_next;
	logic [XLEN-1:0]  a_opa_reg, a_opa_next;
	logic [XLEN-1:0]  a_opb_reg, a_opb_next;
	logic [XLEN-1:0]  a_btgt_reg, a_btgt_next;
	logic             a_null_reg, a_null_next;
	logic             d_v_reg, d_v_next;
	logic             d_ld_reg, d_ld_next;
	logic             d_wr_reg, d_wr_next;
	logic [4:0]       d_dst_reg, d_dst_next;
	logic [XLEN-1:0]  d_res_reg, d_res_next;
	logic [XLEN-1:0]  d_pc_reg, d_pc_next;
	logic             w_v_reg, w_v_next;
	logic             w_wr_reg, w_wr_next;
	logic             w_exc_reg, w_exc_next;
	logic [4:0]       w_dst_reg, w_dst_next;
	logic [XLEN-1:0]  w_res_reg, w_res_next;
	logic [XLEN-1:0]  w_pc_reg, w_pc_next;
	logic [XLEN-1:0]  sd_reg, sd_next;
	logic             se_reg, se_next;
	logic             wb_we_reg, wb_we_next;
	logic [4:0]       wb_dst_reg, wb_dst_next;
	logic [XLEN-1:0]  wb_res_reg, wb_res_next;
	logic             exc_reg, exc_next;
	logic [XLEN-1:0]  exc_pc_reg, exc_pc_next;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic fspc_brk_t br_kind(input logic [31:0] i);
		unique case (i[31:26])
			FSPC_OP_BEQ, FSPC_OP_BNE:   br_kind = FSPC_BR_NORMAL;
			FSPC_OP_BEQL, FSPC_OP_BNEL: br_kind = FSPC_BR_LIKELY;
			default:                    br_kind = FSPC_BR_NONE;
		endcase
	endfunction

	function automatic logic is_known(input logic [31:0] i);
		unique case (i[31:26])
			FSPC_OP_SPECIAL, FSPC_OP_J, FSPC_OP_JAL, FSPC_OP_BEQ, FSPC_OP_BNE,
			FSPC_OP_BEQL, FSPC_OP_BNEL, FSPC_OP_ADDIU, FSPC_OP_LW, FSPC_OP_SW:
				is_known = 1'b1;
			default: is_known = 1'b0;
		endcase
	endfunction

	function automatic logic [4:0] dst_of(input logic [31:0] i);
		dst_of = (i[31:26] == FSPC_OP_SPECIAL) ? i[15:11] :
			(i[31:26] == FSPC_OP_JAL) ? 5'h1F : i[20:16];
	endfunction

	function automatic logic writes_rf(input logic [31:0] i);
		writes_rf = (i[31:26] == FSPC_OP_SPECIAL && i[5:0] != FSPC_FN_JR) ||
			i[31:26] == FSPC_OP_ADDIU || i[31:26] == FSPC_OP_LW ||
			i[31:26] == FSPC_OP_JAL;
	endfunction

	// ****************************************
	// combinational control
	// ****************************************
	logic [XLEN-1:0]  jt, rt, bt, fwd_a, fwd_b, sum, ld_data;
	logic             ph2, load_hazard, br_taken, is_br, is_jmp, is_jr, ri;
	logic             d_exc, kill;

	fspc_target u_target (
		.insn       (r_insn_reg),
		.pc         (r_pc_reg),
		.rs_val     (rf_rdata_a),
		.jump_tgt   (jt),
		.reg_tgt    (rt),
		.branch_tgt (bt)
	);

	always_comb begin
		ph2         = (phase_reg == FSPC_PH_2);
		rf_raddr_a  = r_insn_reg[25:21];
		rf_raddr_b  = r_insn_reg[20:16];
		// load result not ready before the instruction after the load slot
		load_hazard = r_v_reg && a_v_reg && a_insn_reg[31:26] == FSPC_OP_LW &&
			(dst_of(a_insn_reg) == r_insn_reg[25:21] ||
			dst_of(a_insn_reg) == r_insn_reg[20:16]);
		slip        = r_v_reg && !exc_reg && (load_hazard || muldiv_start_slip ||
			fp_coproc_busy_slip || instr_cache_miss || instr_translation_miss);
		stall       = data_cache_miss || coproc_possible_exception;
		// forwarding from data stage, load data arrives in writeback latch
		fwd_a = a_opa_reg;
		fwd_b = a_opb_reg;
		if (w_wr_reg && w_dst_reg == a_insn_reg[25:21] && w_dst_reg != 5'h00)
			fwd_a = w_res_reg;
		if (w_wr_reg && w_dst_reg == a_insn_reg[20:16] && w_dst_reg != 5'h00)
			fwd_b = w_res_reg;
		if (d_wr_reg && !d_ld_reg && d_dst_reg == a_insn_reg[25:21] && d_dst_reg != 5'h00)
			fwd_a = d_res_reg;
		if (d_wr_reg && !d_ld_reg && d_dst_reg == a_insn_reg[20:16] && d_dst_reg != 5'h00)
			fwd_b = d_res_reg;
		sum      = fwd_a + {{16{a_insn_reg[15]}}, a_insn_reg[15:0]};
		br_taken = a_v_reg && !a_null_reg && ((a_insn_reg[26] == 1'b0) ?
			(fwd_a == fwd_b) : (fwd_a != fwd_b)) && br_kind(a_insn_reg) != FSPC_BR_NONE;
		ri       = a_v_reg && !a_null_reg && !is_known(a_insn_reg);
		d_exc    = ri;
		kill     = exc_reg;
		is_br    = br_kind(r_insn_reg) != FSPC_BR_NONE;
		is_jmp   = r_insn_reg[31:26] == FSPC_OP_J || r_insn_reg[31:26] == FSPC_OP_JAL;
		is_jr    = r_insn_reg[31:26] == FSPC_OP_SPECIAL &&
			(r_insn_reg[5:0] == FSPC_FN_JR || r_insn_reg[5:0] == FSPC_FN_JALR);
		ld_data  = load_raw;
	end

	always_comb begin
		phase_next   = ph2 ? FSPC_PH_1 : FSPC_PH_2;
		pc_next      = pc_reg;
		redir_next   = redir_reg;
		redir_v_next = redir_v_reg;
		r_v_next = r_v_reg;       r_insn_next = r_insn_reg; r_pc_next = r_pc_reg;
		a_v_next = a_v_reg;       a_insn_next = a_insn_reg; a_pc_next = a_pc_reg;
		a_opa_next = a_opa_reg;   a_opb_next = a_opb_reg;   a_btgt_next = a_btgt_reg;
		a_null_next = a_null_reg;
		d_v_next = d_v_reg;       d_ld_next = d_ld_reg;     d_wr_next = d_wr_reg;
		d_dst_next = d_dst_reg;   d_res_next = d_res_reg;   d_pc_next = d_pc_reg;
		w_v_next = w_v_reg;       w_wr_next = w_wr_reg;     w_exc_next = w_exc_reg;
		w_dst_next = w_dst_reg;   w_res_next = w_res_reg;   w_pc_next = w_pc_reg;
		sd_next = sd_reg;         se_next = 1'b0;
		wb_we_next = 1'b0;        wb_dst_next = wb_dst_reg; wb_res_next = wb_res_reg;
		exc_next = exc_reg;       exc_pc_next = exc_pc_reg;
		if (ph2 && !stall) begin
			// writeback: exception state resolved first, write only if clean
			exc_next    = w_v_reg && w_exc_reg;
			exc_pc_next = w_pc_reg;
			// instructions older than an excepting one still retire their write
			wb_we_next  = w_v_reg && w_wr_reg && !w_exc_reg;
			wb_dst_next = w_dst_reg;
			wb_res_next = w_res_reg;
			// data to writeback always advances, even in a slip
			w_v_next   = d_v_reg && !kill;
			w_wr_next  = d_wr_reg;
			w_dst_next = d_dst_reg;
			w_res_next = d_ld_reg ? ld_data : d_res_reg;
			w_pc_next  = d_pc_reg;
			w_exc_next = 1'b0;
			// execute to data
			d_v_next   = a_v_reg && !a_null_reg && !kill;
			d_ld_next  = a_insn_reg[31:26] == FSPC_OP_LW;
			d_wr_next  = writes_rf(a_insn_reg) && a_v_reg && !a_null_reg && !d_exc;
			d_dst_next = dst_of(a_insn_reg);
			// link value for calls, register sum for other special words
			if (a_insn_reg[31:26] == FSPC_OP_JAL ||
				(a_insn_reg[31:26] == FSPC_OP_SPECIAL && a_insn_reg[5:0] == FSPC_FN_JALR))
				d_res_next = a_btgt_reg;
			else if (a_insn_reg[31:26] == FSPC_OP_SPECIAL)
				d_res_next = fwd_a + fwd_b;
			else
				d_res_next = sum;
			d_pc_next  = a_pc_reg;
			se_next    = a_v_reg && !a_null_reg && !kill &&
				a_insn_reg[31:26] == FSPC_OP_SW;
			sd_next    = fwd_b;
			if (d_exc && !kill) begin
				w_exc_next = 1'b0;
				d_wr_next  = 1'b0;
				exc_next   = 1'b1;
				exc_pc_next = a_pc_reg;
				d_v_next   = 1'b0;
			end
			if (slip) begin
				a_v_next = 1'b0;
				// a redirect decided now must survive the slip of its delay slot
				if (br_taken) begin
					redir_v_next = 1'b1;
					redir_next   = a_btgt_reg;
				end else if (redir_v_reg && a_v_reg &&
					a_insn_reg[31:26] == FSPC_OP_SPECIAL) begin
					redir_next   = fwd_a;
				end
			end else begin
				// register to execute issue
				a_v_next    = r_v_reg && !kill && !d_exc;
				a_insn_next = r_insn_reg;
				a_pc_next   = r_pc_reg;
				a_opa_next  = rf_rdata_a;
				a_opb_next  = rf_rdata_b;
				// the writeback latch reaches the file one clk too late for this read
				if (w_v_reg && w_wr_reg && w_dst_reg == rf_raddr_a && w_dst_reg != 5'h00)
					a_opa_next = w_res_reg;
				if (w_v_reg && w_wr_reg && w_dst_reg == rf_raddr_b && w_dst_reg != 5'h00)
					a_opb_next = w_res_reg;
				a_btgt_next = r_pc_reg + FSPC_INSN_STEP + FSPC_INSN_STEP;  // link value
				a_null_next = 1'b0;
				// delay slot of an untaken likely branch carries no effect
				if (br_kind(a_insn_reg) == FSPC_BR_LIKELY && a_v_reg && !br_taken)
					a_null_next = 1'b1;
				// jumps redirect after the slot instruction, which is in fetch now
				redir_v_next = r_v_reg && (is_jmp || is_jr);
				redir_next   = is_jr ? rt : jt;
				if (is_br)
					a_btgt_next = bt;
				r_v_next    = !kill && !d_exc;
				r_insn_next = fetch_insn;
				r_pc_next   = pc_reg;
				pc_next     = pc_reg + FSPC_INSN_STEP;
				if (br_taken)
					pc_next = a_btgt_reg;
				else if (redir_v_reg)
					pc_next = (a_v_reg && a_insn_reg[31:26] == FSPC_OP_SPECIAL) ?
						fwd_a : redir_reg;
				// the word fetched after the slot is the fall-through path: drop it
				if (br_taken || redir_v_reg)
					r_v_next = 1'b0;
			end
			if (kill) begin
				a_v_next    = 1'b0;
				r_v_next    = 1'b0;
				redir_v_next = 1'b0;
				pc_next     = FSPC_RESET_PC;
				exc_next    = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_reg <= FSPC_PH_1;
			pc_reg <= FSPC_RESET_PC;  redir_reg <= '0;  redir_v_reg <= 1'b0;
			r_v_reg <= 1'b0;  r_insn_reg <= FSPC_NOP;  r_pc_reg <= '0;
			a_v_reg <= 1'b0;  a_insn_reg <= FSPC_NOP;  a_pc_reg <= '0;
			a_opa_reg <= '0;  a_opb_reg <= '0;  a_btgt_reg <= '0;  a_null_reg <= 1'b0;
			d_v_reg <= 1'b0;  d_ld_reg <= 1'b0;  d_wr_reg <= 1'b0;
			d_dst_reg <= '0;  d_res_reg <= '0;  d_pc_reg <= '0;
			w_v_reg <= 1'b0;  w_wr_reg <= 1'b0;  w_exc_reg <= 1'b0;
			w_dst_reg <= '0;  w_res_reg <= '0;  w_pc_reg <= '0;
			sd_reg <= '0;  se_reg <= 1'b0;
			wb_we_reg <= 1'b0;  wb_dst_reg <= '0;  wb_res_reg <= '0;
			exc_reg <= 1'b0;  exc_pc_reg <= '0;
		end else begin
			phase_reg <= phase_next;
			pc_reg <= pc_next;  redir_reg <= redir_next;  redir_v_reg <= redir_v_next;
			r_v_reg <= r_v_next;  r_insn_reg <= r_insn_next;  r_pc_reg <= r_pc_next;
			a_v_reg <= a_v_next;  a_insn_reg <= a_insn_next;  a_pc_reg <= a_pc_next;
			a_opa_reg <= a_opa_next;  a_opb_reg <= a_opb_next;
			a_btgt_reg <= a_btgt_next;  a_null_reg <= a_null_next;
			d_v_reg <= d_v_next;  d_ld_reg <= d_ld_next;  d_wr_reg <= d_wr_next;
			d_dst_reg <= d_dst_next;  d_res_reg <= d_res_next;  d_pc_reg <= d_pc_next;
			w_v_reg <= w_v_next;  w_wr_reg <= w_wr_next;  w_exc_reg <= w_exc_next;
			w_dst_reg <= w_dst_next;  w_res_reg <= w_res_next;  w_pc_reg <= w_pc_next;
			sd_reg <= sd_next;  se_reg <= se_next;
			wb_we_reg <= wb_we_next;  wb_dst_reg <= wb_dst_next;  wb_res_reg <= wb_res_next;
			exc_reg <= exc_next;  exc_pc_reg <= exc_pc_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	always_comb begin
		fetch_addr     = pc_reg;
		alt_fetch_addr = a_btgt_reg;
		itrans_start   = !ph2 && !stall;
		icache_start   = ph2 && !stall;
		dcache_start   = ph2 && a_v_reg && !a_null_reg &&
			(a_insn_reg[31:26] == FSPC_OP_LW || a_insn_reg[31:26] == FSPC_OP_SW);
		dtrans_start   = dcache_start;
		jtrans_start   = !ph2 && d_v_reg && d_ld_reg;
		data_addr      = sum;
		store_data     = sd_reg;
		store_en       = se_reg;
		rf_we          = wb_we_reg;
		rf_waddr       = wb_dst_reg;
		rf_wdata       = wb_res_reg;
		reserved_instr_exception = exc_reg;
		exc_pc         = exc_pc_reg;
	end
endmodule // fspc_core

// ===== rtl/fspc_pkg.sv
// Purpose: shared constants and types for the five-stage pipeline control
// Assumes: 32-bit addresses, 32-bit instruction words
// Notes:   phases are modelled as the two halves of one clk period pair
package fspc_pkg;

	localparam int          FSPC_XLEN        = 32;
	localparam int          FSPC_JT_W        = 26;
	localparam int          FSPC_PC_HI_W     = 4;
	localparam int          FSPC_OFF_W       = 16;
	localparam int          FSPC_RIDX_W      = 5;
	localparam logic [31:0] FSPC_RESET_PC    = 32'hBFC0_0000;
	localparam logic [31:0] FSPC_NOP         = 32'h0000_0000;
	localparam logic [31:0] FSPC_INSN_STEP   = 32'h0000_0004;

	// opcode and function field values used by the decoder
	localparam logic [5:0]  FSPC_OP_SPECIAL  = 6'h00;
	localparam logic [5:0]  FSPC_OP_J        = 6'h02;
	localparam logic [5:0]  FSPC_OP_JAL      = 6'h03;
	localparam logic [5:0]  FSPC_OP_BEQ      = 6'h04;
	localparam logic [5:0]  FSPC_OP_BNE      = 6'h05;
	localparam logic [5:0]  FSPC_OP_BEQL     = 6'h14;
	localparam logic [5:0]  FSPC_OP_BNEL     = 6'h15;
	localparam logic [5:0]  FSPC_OP_ADDIU    = 6'h09;
	localparam logic [5:0]  FSPC_OP_LW       = 6'h23;
	localparam logic [5:0]  FSPC_OP_SW       = 6'h2B;
	localparam logic [5:0]  FSPC_FN_JR       = 6'h08;
	localparam logic [5:0]  FSPC_FN_JALR     = 6'h09;

	typedef enum logic [1:0] {
		FSPC_PH_1 = 2'b01,
		FSPC_PH_2 = 2'b10
	} fspc_phase_t;

	typedef enum logic [2:0] {
		FSPC_BR_NONE   = 3'b001,
		FSPC_BR_NORMAL = 3'b010,
		FSPC_BR_LIKELY = 3'b100
	} fspc_brk_t;

endpackage

// ===== rtl/fspc_target.sv
// Purpose: jump and branch target formation
// Assumes: delay-slot address is pc of branch plus one instruction
// Notes:   pure combinational
`timescale 1ns/1ps
module fspc_target (
	// instruction and addresses
	input  wire logic [31:0]                   insn,
	input  wire logic [fspc_pkg::FSPC_XLEN-1:0] pc,
	input  wire logic [fspc_pkg::FSPC_XLEN-1:0] rs_val,
	// targets
	output logic      [fspc_pkg::FSPC_XLEN-1:0] jump_tgt,
	output logic      [fspc_pkg::FSPC_XLEN-1:0] reg_tgt,
	output logic      [fspc_pkg::FSPC_XLEN-1:0] branch_tgt
);
	import fspc_pkg::*;
	logic [FSPC_XLEN-1:0] slot_pc;

	always_comb begin
		slot_pc    = pc + FSPC_INSN_STEP;
		jump_tgt   = {slot_pc[31:28], insn[25:0], 2'b00};
		reg_tgt    = rs_val;
		branch_tgt = slot_pc + {{14{insn[15]}}, insn[15:0], 2'b00};
	end
endmodule // fspc_target

// ===== verif/fspc_core_monitor.sv
// Purpose: port-level checks for the pipeline control
// Assumes: one clock, synchronous active-high reset
// Notes:   phase is read from the start strobes, not from internal state
`timescale 1ns/1ps
module fspc_core_monitor (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// watched outputs
	input wire logic [31:0] fetch_addr,
	input wire logic        itrans_start,
	input wire logic        icache_start,
	input wire logic        dcache_start,
	input wire logic        dtrans_start,
	input wire logic        jtrans_start,
	input wire logic        rf_we,
	input wire logic        stall,
	input wire logic        slip,
	input wire logic        reserved_instr_exception
);
	import fspc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ************************************************
	// properties
	// ************************************************
	sequence exc_two_clk;
		reserved_instr_exception [*2] ##1 !reserved_instr_exception;
	endsequence
	sequence fetch_pair;
		itrans_start ##1 !stall;
	endsequence
	reset_pc_a: assert property ($fell(rst) |-> fetch_addr == FSPC_RESET_PC)
		else $error("fetch address not at reset pc after reset");
	fetch_phase_a: assert property (fetch_pair |-> icache_start)
		else $error("cache read did not follow translation start");
	stall_quiet_a: assert property (stall |-> !itrans_start && !icache_start)
		else $error("fetch started while stalled");
	stall_freeze_a: assert property (stall |=> $stable(fetch_addr))
		else $error("fetch address moved during stall");
	slip_hold_a: assert property (slip && !stall |=> $stable(fetch_addr))
		else $error("fetch address moved during slip");
	data_phase_a: assert property (dcache_start |-> dtrans_start && !itrans_start)
		else $error("data access not in execute phase two");
	joint_phase_a: assert property (jtrans_start |-> !icache_start && !dcache_start)
		else $error("joint translation outside data phase one");
	wb_pulse_a: assert property (rf_we |=> !rf_we)
		else $error("register write longer than one clock");
	exc_pulse_a: assert property ($rose(reserved_instr_exception) |-> exc_two_clk)
		else $error("exception flag not one pipeline cycle");
	exc_restart_a: assert property ($rose(reserved_instr_exception) |-> ##[0:16] fetch_addr == FSPC_RESET_PC)
		else $error("fetch did not restart after exception");
endmodule // fspc_core_monitor

// ===== verif/fspc_mem_model.sv
// Purpose: caches, translation and register file seen by the pipeline control
// Assumes: 256-word instruction and data arrays, address bits above 9 ignored
// Notes:   always hits; misses are commanded by the bench on the core inputs
`timescale 1ns/1ps
module fspc_mem_model (
	// clock
	input wire logic         clk,
	// instruction side
	input wire logic  [31:0] fetch_addr,
	output logic      [31:0] fetch_insn,
	// data side
	input wire logic         dcache_start,
	input wire logic  [31:0] data_addr,
	input wire logic  [31:0] store_data,
	input wire logic         store_en,
	output logic      [31:0] load_raw,
	// register file
	input wire logic  [4:0]  rf_raddr_a,
	input wire logic  [4:0]  rf_raddr_b,
	output logic      [31:0] rf_rdata_a,
	output logic      [31:0] rf_rdata_b,
	input wire logic         rf_we,
	input wire logic  [4:0]  rf_waddr,
	input wire logic  [31:0] rf_wdata
);
	logic [31:0] imem [256];
	logic [31:0] dmem [256];
	logic [31:0] regs [32];
	logic [31:0] lat_addr = 32'h0000_0000;
	assign fetch_insn = imem[fetch_addr[9:2]];
	// address is latched when the access starts; the data stage reads it later
	assign load_raw   = dmem[lat_addr[9:2]];
	assign rf_rdata_a = (rf_raddr_a == 5'h00) ? 32'h0000_0000 : regs[rf_raddr_a];
	assign rf_rdata_b = (rf_raddr_b == 5'h00) ? 32'h0000_0000 : regs[rf_raddr_b];
	always @(posedge clk) begin
		if (dcache_start)
			lat_addr <= data_addr;
		if (store_en)
			dmem[lat_addr[9:2]] <= store_data;
		if (rf_we)
			regs[rf_waddr] <= rf_wdata;
	end
endmodule // fspc_mem_model

// ===== verif/tb_fspc_core.sv
// Purpose: self-checking bench for the pipeline control
// Assumes: programs live in the memory model, results seen as register writes
// Notes:   each scenario reloads the program and resets the core
`timescale 1ns/1ps
module tb_fspc_core;
	import fspc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  cond = 6'h00;
	logic        instr_translation_miss, instr_cache_miss, data_cache_miss;
	logic        coproc_possible_exception, muldiv_start_slip, fp_coproc_busy_slip;
	logic [31:0] fetch_addr, alt_fetch_addr, fetch_insn, data_addr, store_data, load_raw;
	logic [31:0] rf_rdata_a, rf_rdata_b, rf_wdata, exc_pc;
	logic [4:0]  rf_raddr_a, rf_raddr_b, rf_waddr;
	logic        itrans_start, icache_start, dcache_start, dtrans_start, jtrans_start;
	logic        store_en, rf_we, stall, slip, reserved_instr_exception;
	logic [36:0] wq [$];
	int          err_count = 0;
	int          cmp_count = 0;
	assign {fp_coproc_busy_slip, muldiv_start_slip, coproc_possible_exception, data_cache_miss,
		instr_cache_miss, instr_translation_miss} = cond;
	always #12.5 clk = ~clk;
	fspc_core u_fspc_core (.clk, .rst, .fetch_addr, .itrans_start, .icache_start, .alt_fetch_addr,
		.fetch_insn, .instr_translation_miss, .instr_cache_miss, .dcache_start, .dtrans_start,
		.jtrans_start, .data_addr, .store_data, .store_en, .load_raw, .data_cache_miss,
		.coproc_possible_exception, .muldiv_start_slip, .fp_coproc_busy_slip, .rf_raddr_a,
		.rf_raddr_b, .rf_rdata_a, .rf_rdata_b, .rf_we, .rf_waddr, .rf_wdata, .stall, .slip,
		.reserved_instr_exception, .exc_pc);
	fspc_mem_model u_fspc_mem_model (.clk, .fetch_addr, .fetch_insn, .dcache_start, .data_addr,
		.store_data, .store_en, .load_raw, .rf_raddr_a, .rf_raddr_b, .rf_rdata_a, .rf_rdata_b,
		.rf_we, .rf_waddr, .rf_wdata);
	// writes to register zero are ignored so nops do not clutter the record
	always @(posedge clk)
		if (!rst && rf_we === 1'b1 && rf_waddr !== 5'h00) wq.push_back({rf_waddr, rf_wdata});
	// ************************************************
	// helpers
	// ************************************************
	function automatic logic [31:0] it(logic [5:0] op, int rs, int rt, int imm);
		return {op, 5'(rs), 5'(rt), 16'(imm)};
	endfunction
	function automatic logic [36:0] w(int r, int v);
		return {5'(r), 32'(v)};
	endfunction
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic compare_val(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic clear_mem();
		for (int i = 0; i < 256; i++) begin
			u_fspc_mem_model.imem[i] = FSPC_NOP;
			u_fspc_mem_model.dmem[i] = 32'h0000_0000;
		end
		for (int i = 0; i < 32; i++) u_fspc_mem_model.regs[i] = 32'h0000_0000;
	endtask
	task automatic load(input int idx, input logic [31:0] word);
		u_fspc_mem_model.imem[idx] = word;
	endtask
	task automatic restart(input int n);
		@(posedge clk);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		wq.delete();
	endtask
	task automatic wait_fetch(input logic [31:0] addr);
		int guard;
		guard = 0;
		while (fetch_addr !== addr && guard < 80) begin
			@(posedge clk);
			#1;
			guard++;
		end
		compare_val("fetch address", addr, fetch_addr);
		if (guard >= 80) give_verdict();
	endtask
	task automatic expect_writes(input logic [36:0] exp [$]);
		int guard;
		guard = 0;
		while (wq.size() < exp.size() && guard < 400) begin
			@(posedge clk);
			guard++;
		end
		repeat (20) @(posedge clk);
		compare_val("write count", exp.size(), wq.size());
		foreach (exp[i]) if (i < wq.size()) compare_val("register write", exp[i], wq[i]);
		if (guard >= 400) give_verdict();
	endtask
	task automatic hold_cond(input int b);
		@(posedge clk);
		cond[b] <= 1'b1;
		@(posedge clk);
		#1;
		if (b == 2 || b == 3)
			compare_val("stall level", 1, stall);
		else
			compare_val("slip level", 1, slip);
		repeat (4) @(posedge clk);
		cond[b] <= 1'b0;
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task automatic sc_jump();
		clear_mem();
		load(0, {FSPC_OP_J, 26'h000_0040});
		load(1, it(FSPC_OP_ADDIU, 0, 1, 1));
		load(2, it(FSPC_OP_ADDIU, 0, 2, 2));
		load(64, it(FSPC_OP_ADDIU, 0, 3, 3));
		restart(10);
		wait_fetch(32'hB000_0100);
		expect_writes('{w(1, 1), w(3, 3)});
	endtask
	task automatic sc_jr();
		clear_mem();
		load(0, it(FSPC_OP_ADDIU, 0, 4, 256));
		load(1, {FSPC_OP_SPECIAL, 5'h04, 15'h0000, FSPC_FN_JR});
		load(2, it(FSPC_OP_ADDIU, 0, 5, 5));
		load(3, it(FSPC_OP_ADDIU, 0, 6, 6));
		load(64, it(FSPC_OP_ADDIU, 0, 7, 7));
		restart(2);
		wait_fetch(32'h0000_0100);
		expect_writes('{w(4, 256), w(5, 5), w(7, 7)});
	endtask
	task automatic sc_branch();
		clear_mem();
		load(0, it(FSPC_OP_BEQ, 0, 0, 7));
		load(1, it(FSPC_OP_ADDIU, 0, 1, 1));
		load(2, it(FSPC_OP_ADDIU, 0, 2, 2));
		load(3, it(FSPC_OP_ADDIU, 0, 3, 3));
		load(4, {FSPC_OP_J, 26'h000_00C8});
		load(5, it(FSPC_OP_ADDIU, 0, 5, 5));
		load(8, it(FSPC_OP_BEQ, 0, 0, -6));
		load(9, it(FSPC_OP_ADDIU, 0, 9, 9));
		load(10, it(FSPC_OP_ADDIU, 0, 10, 10));
		restart(2);
		wait_fetch(32'hBFC0_000C);
		wait_fetch(32'hB000_0320);
		expect_writes('{w(1, 1), w(9, 9), w(3, 3), w(5, 5)});
	endtask
	task automatic sc_likely();
		clear_mem();
		load(0, it(FSPC_OP_ADDIU, 0, 1, 1));
		load(1, it(FSPC_OP_BEQL, 1, 0, 5));
		load(2, it(FSPC_OP_ADDIU, 0, 2, 2));
		// reads r1 three slots on, while only the writeback latch holds it
		load(3, it(FSPC_OP_ADDIU, 1, 3, 2));
		load(4, it(FSPC_OP_BNE, 0, 0, 5));
		load(5, it(FSPC_OP_ADDIU, 0, 5, 5));
		load(6, it(FSPC_OP_BNEL, 1, 0, 2));
		load(7, it(FSPC_OP_ADDIU, 0, 7, 7));
		load(8, it(FSPC_OP_ADDIU, 0, 8, 8));
		load(9, it(FSPC_OP_ADDIU, 0, 9, 9));
		restart(2);
		expect_writes('{w(1, 1), w(3, 3), w(5, 5), w(7, 7), w(9, 9)});
	endtask
	task automatic sc_load();
		clear_mem();
		u_fspc_mem_model.dmem[4] = 32'h0000_1234;
		u_fspc_mem_model.dmem[8] = 32'h0000_0100;
		load(0, it(FSPC_OP_LW, 0, 2, 16));
		load(1, it(FSPC_OP_ADDIU, 0, 3, 3));
		load(2, it(FSPC_OP_ADDIU, 2, 4, 1));
		load(3, it(FSPC_OP_LW, 0, 5, 32));
		load(4, it(FSPC_OP_ADDIU, 5, 6, 2));
		load(5, it(FSPC_OP_SW, 0, 4, 48));
		restart(2);
		expect_writes('{w(2, 4660), w(3, 3), w(4, 4661), w(5, 256), w(6, 258)});
		compare_val("stored word", 32'h0000_1235, u_fspc_mem_model.dmem[12]);
	endtask
	task automatic sc_interlock();
		logic [36:0] exp [$];
		clear_mem();
		for (int i = 0; i < 14; i++) load(i, it(FSPC_OP_ADDIU, 0, i + 1, i + 1));
		for (int i = 0; i < 14; i++) exp.push_back(w(i + 1, i + 1));
		restart(2);
		for (int b = 0; b < 6; b++) hold_cond(b);
		expect_writes(exp);
	endtask
	task automatic sc_reserved();
		int guard;
		int n;
		clear_mem();
		load(0, it(FSPC_OP_ADDIU, 0, 1, 1));
		load(1, 32'hFC00_0000);
		load(2, it(FSPC_OP_ADDIU, 0, 2, 2));
		restart(2);
		guard = 0;
		n = 0;
		while (reserved_instr_exception !== 1'b1 && guard < 80) begin
			@(posedge clk);
			#1;
			guard++;
		end
		compare_val("exception pc", 32'hBFC0_0004, exc_pc);
		if (guard >= 80) begin
			err_count++;
			give_verdict();
		end
		repeat (20) @(posedge clk);
		foreach (wq[i]) if (wq[i][36:32] == 5'h02) n++;
		compare_val("cancelled writes", 0, n);
		compare_val("older write", w(1, 1), (wq.size() > 0) ? wq[0] : 37'h0);
	endtask
	initial begin
		sc_jump();
		sc_jr();
		sc_branch();
		sc_likely();
		sc_load();
		sc_interlock();
		sc_reserved();
		give_verdict();
	end
endmodule // tb_fspc_core
bind fspc_core fspc_core_monitor u_fspc_core_monitor (.clk, .rst, .fetch_addr, .itrans_start,
	.icache_start, .dcache_start, .dtrans_start, .jtrans_start, .rf_we, .stall, .slip,
	.reserved_instr_exception);
